// *** area_learning_cfg.svh ***
// Timing, level and field constants for the area algorithm learning block
`ifndef AREA_LEARNING_CFG_SVH
`define AREA_LEARNING_CFG_SVH
`define CLK_HZ 32'd20000000
`define CYC_PER_SEC (`CLK_HZ)
`define SEC_PER_AVG 32'd780
`define SEC_PER_HALF 32'd64800
`define SEC_PER_SLOT 32'd129600
`define SLOTS_PER_PERIOD 5'd20
`define MARKS_TO_ADAPT 5'd3
`define MONTH_SLOTS 5'd20
`define HEAT_LEVEL 16'h00c0
`define COMB_LEVEL 16'h00a0
`define COMB_SMOKE_MIN 16'h0028
`define COMB_RISE_MIN 16'h0030
`define FACTOR_MAX 16'h0020
`define POLL_ON_MS 32'd20
`define POLL_PERIOD_S 32'd7
`define POLL_ON_CYC ((`CLK_HZ / 32'd1000) * `POLL_ON_MS)
`define OFFS_CTRL 4'h0
`define OFFS_STATUS 4'h4
`define OFFS_ANALOG 4'h8
`define OFFS_FACTOR 4'hc
`endif

// *** area_learning_pkg.sv ***
// Types shared by the area algorithm learning block
`default_nettype none
package area_learning_pkg;
    typedef enum logic [4:0] {
        ALG_NORMAL = 5'h01,
        ALG_SMOKE = 5'h02,
        ALG_HEATER = 5'h04,
        ALG_COOK = 5'h08,
        ALG_CLEAN = 5'h10
    } area_alg_t;
    typedef enum logic [1:0] {
        VAR_FULL = 2'h0,
        VAR_SMOKE_ONLY = 2'h1,
        VAR_NONE = 2'h2
    } variant_t;
endpackage : area_learning_pkg
`default_nettype wire

// *** area_algorithm_learning.sv ***
// Area alarm algorithm learning, contamination compensation and indicators
// Notes on behaviour
// - Normal algorithm by default after power-on
// - Smoke level: compensated smoke >= half threshold
// - Heater level: rise over 168s >= 12
// - Cooking level: 2S+rise >= 10, S>=2.5, rise>=3
// - Mark slot when level exceeded once
// - Adapt smoke/steam at three marked slots
// - After slot 20 restart period, inherit marks
// - Revert below three marks, re-adapt later
// - Same procedure for heater and cooking levels
// - Clean only without marks, after one month
// - Clean reverts to normal on any mark
// - Variant selects adaptable algorithm set
// - Analog value each second, four-second smoke average
// - Full variant reports smoke, temperature, algorithm, factor
// - Subtract factor from each smoke sample
// - Every 13 minutes average, early only decrease
// - From 18 hours also increase factor
// - At 36 hours update, store, restart cycle
// - Factor capped at 2 %/m, service signal; the code suppresses service_out in VAR_NONE
// - Failed self check reports fault; the code suppresses fault_out in VAR_NONE
// - Address 000 blinks red once every two seconds, one second on and one off
// - Green 20 ms every 7 s, off in test
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`default_nettype none
`include "area_learning_cfg.svh"
module area_algorithm_learning
    import area_learning_pkg::*;
#(
    parameter int SMOKE_W = 16,
    parameter logic [31:0] CYC_PER_SEC = `CYC_PER_SEC,
    parameter logic [31:0] SEC_PER_AVG = `SEC_PER_AVG,
    parameter logic [31:0] SEC_PER_HALF = `SEC_PER_HALF,
    parameter logic [31:0] SEC_PER_SLOT = `SEC_PER_SLOT
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Sensor samples, one per clock, units of 1/16 %/m and 1/16 degree
    input wire logic [SMOKE_W-1:0] smoke_raw_in,
    input wire logic [SMOKE_W-1:0] temperature_in,
    input wire logic [SMOKE_W-1:0] temperature_rise_rate_in,
    input wire logic [SMOKE_W-1:0] smoke_threshold_in,
    // Configuration
    input wire logic [1:0] variant_in,
    input wire logic [7:0] loop_address_in,
    input wire logic polling_led_enable_in,
    input wire logic test_mode_in,
    input wire logic self_check_fail_in,
    input wire logic [SMOKE_W-1:0] stored_factor_in,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Results toward the addressable_loop
    output logic [SMOKE_W-1:0] analog_smoke_out,
    output logic [SMOKE_W-1:0] analog_temperature_out,
    output logic [4:0] area_algorithm_out,
    output logic [SMOKE_W-1:0] contamination_comp_factor_out,
    output logic factor_store_out,
    output logic service_out,
    output logic fault_out,
    output logic red_led_out,
    output logic green_led_out
);
    function automatic logic [4:0] count_marks(input logic [19:0] m);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 20; i++) begin
            c = c + {4'h0, m[i]};
        end
        return c;
    endfunction : count_marks

    // Time base
    logic [31:0] cyc_cnt;
    logic [31:0] sec_cnt;
    logic [31:0] avg_sec;
    logic [2:0] poll_sec;
    logic [4:0] slot_idx;
    logic [4:0] slots_seen;
    logic sec_tick, avg_tick, slot_tick, late_half;
    assign sec_tick = (cyc_cnt == CYC_PER_SEC - 32'h1);
    assign avg_tick = sec_tick && (avg_sec == SEC_PER_AVG - 32'h1);
    assign slot_tick = sec_tick && (sec_cnt == SEC_PER_SLOT - 32'h1);
    assign late_half = (sec_cnt >= SEC_PER_HALF);

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cyc_cnt <= 32'h0;
            sec_cnt <= 32'h0;
            avg_sec <= 32'h0;
        end else begin
            cyc_cnt <= sec_tick ? 32'h0 : cyc_cnt + 32'h1;
            if (sec_tick) begin
                sec_cnt <= slot_tick ? 32'h0 : sec_cnt + 32'h1;
                avg_sec <= avg_tick ? 32'h0 : avg_sec + 32'h1;
            end
        end
    end

    // Per-second samples and compensation
    logic [SMOKE_W-1:0] factor;
    logic [SMOKE_W-1:0] smoke_comp;
    assign smoke_comp = (smoke_raw_in > factor) ? smoke_raw_in - factor : '0;

    logic lvl_smoke, lvl_heat, lvl_cook;
    logic [SMOKE_W:0] comb_val;
    assign comb_val = {smoke_comp, 1'b0} + {1'b0, temperature_rise_rate_in};
    assign lvl_smoke = {smoke_comp, 1'b0} >= {1'b0, smoke_threshold_in};
    assign lvl_heat = temperature_rise_rate_in >= `HEAT_LEVEL;
    assign lvl_cook = comb_val >= {1'b0, `COMB_LEVEL} && smoke_comp >= `COMB_SMOKE_MIN
        && temperature_rise_rate_in >= `COMB_RISE_MIN;

    // Four second smoke average
    logic [SMOKE_W-1:0] hist [3];
    logic [SMOKE_W+1:0] sum4;
    assign sum4 = {2'b00, smoke_comp} + {2'b00, hist[0]} + {2'b00, hist[1]} + {2'b00, hist[2]};
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            hist[0] <= '0;
            hist[1] <= '0;
            hist[2] <= '0;
            analog_smoke_out <= '0;
            analog_temperature_out <= '0;
        end else if (sec_tick) begin
            hist[0] <= smoke_comp;
            hist[1] <= hist[0];
            hist[2] <= hist[1];
            analog_smoke_out <= sum4[SMOKE_W+1:2];
            analog_temperature_out <= (variant_t'(variant_in) == VAR_FULL) ? temperature_in : '0;
        end
    end

    // Slot marks per level
    logic [19:0] mark_s, mark_h, mark_c;
    logic cur_s, cur_h, cur_c;
    logic [19:0] slot_bit;
    assign slot_bit = 20'h1 << slot_idx;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            mark_s <= '0;
            mark_h <= '0;
            mark_c <= '0;
            cur_s <= 1'b0;
            cur_h <= 1'b0;
            cur_c <= 1'b0;
            slot_idx <= 5'h0;
            slots_seen <= 5'h0;
        end else if (sec_tick) begin
            // Current slot mark is rewritten live, replacing the mark inherited from the last period
            cur_s <= slot_tick ? 1'b0 : cur_s | lvl_smoke;
            cur_h <= slot_tick ? 1'b0 : cur_h | lvl_heat;
            cur_c <= slot_tick ? 1'b0 : cur_c | lvl_cook;
            mark_s <= (mark_s & ~slot_bit) | ((cur_s | lvl_smoke) ? slot_bit : 20'h0);
            mark_h <= (mark_h & ~slot_bit) | ((cur_h | lvl_heat) ? slot_bit : 20'h0);
            mark_c <= (mark_c & ~slot_bit) | ((cur_c | lvl_cook) ? slot_bit : 20'h0);
            if (slot_tick) begin
                slot_idx <= (slot_idx == `SLOTS_PER_PERIOD - 5'h1) ? 5'h0 : slot_idx + 5'h1;
                if (slots_seen != `MONTH_SLOTS) begin
                    slots_seen <= slots_seen + 5'h1;
                end
            end
        end
    end

    // Algorithm choice
    area_alg_t alg, next_alg;
    logic [4:0] cnt_s, cnt_h, cnt_c;
    assign cnt_s = count_marks(mark_s);
    assign cnt_h = count_marks(mark_h);
    assign cnt_c = count_marks(mark_c);
    always_comb begin
        next_alg = ALG_NORMAL;
        case (variant_t'(variant_in))
            VAR_FULL: begin
                if (cnt_s >= `MARKS_TO_ADAPT) next_alg = ALG_SMOKE;
                else if (cnt_h >= `MARKS_TO_ADAPT) next_alg = ALG_HEATER;
                else if (cnt_c >= `MARKS_TO_ADAPT) next_alg = ALG_COOK;
                else if ((mark_s | mark_h | mark_c) == 20'h0 && slots_seen == `MONTH_SLOTS)
                    next_alg = ALG_CLEAN;
            end
            VAR_SMOKE_ONLY: begin
                if (cnt_s >= `MARKS_TO_ADAPT) next_alg = ALG_SMOKE;
                else if ((mark_s | mark_h | mark_c) == 20'h0 && slots_seen == `MONTH_SLOTS)
                    next_alg = ALG_CLEAN;
            end
            default: next_alg = ALG_NORMAL;
        endcase
    end
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) alg <= ALG_NORMAL;
        else alg <= next_alg;
    end
    assign area_algorithm_out = alg;

    // Contamination factor, 13 minute average
    logic [47:0] avg_acc;
    logic [31:0] avg_n;
    logic [SMOKE_W-1:0] avg_val, next_factor;
    logic at_end, ctrl_reload;
    assign at_end = slot_tick;
    assign avg_val = SMOKE_W'((avg_acc + {32'h0, smoke_raw_in}) / {16'h0, avg_n + 32'h1});
    always_comb begin
        next_factor = factor;
        if (avg_val < factor || late_half || at_end) begin
            next_factor = avg_val;
        end
        if (next_factor > `FACTOR_MAX) next_factor = `FACTOR_MAX;
    end
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            factor <= '0;
            avg_acc <= 48'h0;
            avg_n <= 32'h0;
            factor_store_out <= 1'b0;
        end else begin
            factor_store_out <= 1'b0;
            if (ctrl_reload) begin
                factor <= (stored_factor_in > `FACTOR_MAX) ? `FACTOR_MAX : stored_factor_in;
            end else if (avg_tick || slot_tick) begin
                factor <= next_factor;
                factor_store_out <= at_end;
            end
            if (avg_tick || slot_tick) begin
                avg_acc <= 48'h0;
                avg_n <= 32'h0;
            end else begin
                avg_acc <= avg_acc + {32'h0, smoke_raw_in};
                avg_n <= avg_n + 32'h1;
            end
        end
    end
    assign contamination_comp_factor_out = factor;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            service_out <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            service_out <= (factor >= `FACTOR_MAX) && variant_t'(variant_in) != VAR_NONE;
            fault_out <= self_check_fail_in && variant_t'(variant_in) != VAR_NONE;
        end
    end

    // Indicators
    logic red_phase;
    logic [31:0] green_cnt;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            red_phase <= 1'b0;
            poll_sec <= 3'h0;
            green_cnt <= 32'h0;
            red_led_out <= 1'b0;
            green_led_out <= 1'b0;
        end else begin
            if (sec_tick) begin
                red_phase <= ~red_phase;
                poll_sec <= (poll_sec == 3'(`POLL_PERIOD_S - 32'h1)) ? 3'h0 : poll_sec + 3'h1;
            end
            green_cnt <= (sec_tick && poll_sec == 3'h0) ? 32'h0 : green_cnt + 32'h1;
            red_led_out <= (loop_address_in == 8'h00) && red_phase;
            green_led_out <= polling_led_enable_in && !test_mode_in && poll_sec == 3'h1
                && green_cnt < `POLL_ON_CYC;
        end
    end

    // Register slave: CTRL bit0 reloads stored factor
    logic wr_aw, wr_w;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    assign s_axi_awready = !wr_aw && !s_axi_bvalid;
    assign s_axi_wready = !wr_w && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_bresp = 2'h0;
    assign ctrl_reload = wr_aw && wr_w && wr_addr == `OFFS_CTRL && wr_data[0];
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            wr_aw <= 1'b0;
            wr_w <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_aw <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_w <= 1'b1;
                wr_data <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
            end
            if (wr_aw && wr_w) begin
                wr_aw <= 1'b0;
                wr_w <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `OFFS_CTRL: s_axi_rdata <= 32'h0;
                `OFFS_STATUS: s_axi_rdata <= {20'h0, fault_out, service_out, slot_idx, alg};
                `OFFS_ANALOG: s_axi_rdata <= {analog_temperature_out, analog_smoke_out};
                `OFFS_FACTOR: s_axi_rdata <= {16'h0, factor};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    normal_reset_a: assert property ($rose(slots_seen == 5'h1) |-> alg != ALG_CLEAN)
        else $error("clean before month");
    cap_factor_a: assert property (factor <= `FACTOR_MAX)
        else $error("factor above cap");
    red_off_a: assert property (loop_address_in != 8'h00 |=> !red_led_out)
        else $error("red lit with address");
    green_test_a: assert property (test_mode_in |=> !green_led_out)
        else $error("green lit in test");
    smoke_adapt_a: assert property (variant_in == 2'h0 && cnt_s >= 5'h3 |=> alg == ALG_SMOKE)
        else $error("smoke not adapted");
    no_learn_a: assert property (variant_in == 2'h2 |=> alg == ALG_NORMAL)
        else $error("learning in plain variant");
    clean_revert_a: assert property (alg == ALG_CLEAN && (mark_s | mark_h | mark_c) != 20'h0
        |=> alg != ALG_CLEAN)
        else $error("clean held with mark");
    store_end_a: assert property (factor_store_out |-> $past(slot_tick))
        else $error("store off cycle end");
    smoke_cov_c: cover property (alg == ALG_SMOKE);
    clean_cov_c: cover property (alg == ALG_CLEAN);
    store_cov_c: cover property (factor_store_out);
endmodule : area_algorithm_learning
`default_nettype wire

// *** area_panel_model.sv ***
// Control panel model: AXI4-Lite master that reaches the detector registers
`default_nettype none
module area_panel_model (
    // Clock
    input wire logic clk_in,
    // Write channels
    output logic [3:0] awaddr_out,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    output logic wvalid_out,
    input wire logic wready_in,
    input wire logic [1:0] bresp_in,
    input wire logic bvalid_in,
    output logic bready_out,
    // Read channels
    output logic [3:0] araddr_out,
    output logic arvalid_out,
    input wire logic arready_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    input wire logic rvalid_in,
    output logic rready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out} = '0;
    end
    // Released address and data lines carry inverted leftovers so a stale value is never taken for a live one
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        awaddr_out <= a;
        awvalid_out <= 1'b1;
        wdata_out <= d;
        wstrb_out <= 4'hf;
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awvalid_out && awready_in) begin
                awvalid_out <= 1'b0;
                awaddr_out <= ~a;
            end
            if (wvalid_out && wready_in) begin
                wvalid_out <= 1'b0;
                wdata_out <= ~d;
            end
        end while (bvalid_in !== 1'b1);
        resp = bresp_in;
        bready_out <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr_out <= a;
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arvalid_out && arready_in) begin
                arvalid_out <= 1'b0;
                araddr_out <= ~a;
            end
        end while (rvalid_in !== 1'b1);
        d = rdata_in;
        resp = rresp_in;
        rready_out <= 1'b0;
    endtask : rd
endmodule : area_panel_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the area algorithm learning block
`default_nettype none
`include "area_learning_cfg.svh"
module tb
    import area_learning_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // One second is 4 clocks, one slot 10 seconds
    localparam int SLOT = 40;
    localparam logic [15:0] K_SMOKE [4] = '{16'h0030, 16'h0000, 16'h0028, 16'h0028};
    localparam logic [15:0] K_RISE [4] = '{16'h0000, 16'h00c0, 16'h0050, 16'h004f};
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] smoke = '0, temp = '0, rise = '0, thr = 16'h0060, stored = '0;
    logic [1:0] variant = 2'h0;
    logic [7:0] loop_address = 8'h01;
    logic polling_en = 1'b0, test_mode = 1'b0, self_fail = 1'b0;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] an_smoke, an_temp, comp_factor;
    logic [4:0] alg;
    logic store, service, fault, red, green;
    int num_errors = 0, checks = 0, cyc = 0;

    always #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) cyc <= reset_in ? 0 : cyc + 1;

    area_algorithm_learning #(.CYC_PER_SEC(32'd4), .SEC_PER_AVG(32'd3), .SEC_PER_HALF(32'd5),
        .SEC_PER_SLOT(32'd10)) dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .smoke_raw_in(smoke), .temperature_in(temp),
        .temperature_rise_rate_in(rise), .smoke_threshold_in(thr), .variant_in(variant),
        .loop_address_in(loop_address), .polling_led_enable_in(polling_en), .test_mode_in(test_mode),
        .self_check_fail_in(self_fail), .stored_factor_in(stored),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .analog_smoke_out(an_smoke), .analog_temperature_out(an_temp),
        .area_algorithm_out(alg), .contamination_comp_factor_out(comp_factor), .factor_store_out(store),
        .service_out(service), .fault_out(fault), .red_led_out(red), .green_led_out(green));

    area_panel_model panel (
        .clk_in(clk_sys_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
        .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
        .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
        .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic at(input int t);
        while (cyc < t) @(posedge clk_sys_in);
    endtask : at

    task automatic restart(input logic [1:0] v);
        reset_in <= 1'b1;
        variant <= v;
        smoke <= '0;
        rise <= '0;
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : restart

    // Event kept well inside the first factor half so the average never lifts the factor
    task automatic pulse(input int slot, input int k);
        at(slot * SLOT + 4);
        smoke <= K_SMOKE[k];
        rise <= K_RISE[k];
        at(slot * SLOT + 10);
        smoke <= '0;
        rise <= '0;
    endtask : pulse

    // Selector: 0 red, 1 green, 2 factor store strobe
    task automatic cnt(input int sel, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk_sys_in);
            c += (((sel == 2) ? store : (sel == 1) ? green : red) === 1'b1);
        end
    endtask : cnt

    function automatic logic [4:0] exp_alg(input int k, input logic [1:0] v);
        if (v == VAR_NONE || k == 3) return ALG_NORMAL;
        if (k == 0) return ALG_SMOKE;
        return (v == VAR_FULL) ? ((k == 1) ? ALG_HEATER : ALG_COOK) : ALG_NORMAL;
    endfunction : exp_alg

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        num_errors++;
        summarize();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int c;
        void'($urandom(22));
        for (int k = 0; k < 4; k++) begin
            for (int v = 0; v < 3; v++) begin
                restart(v[1:0]);
                temp <= 16'($urandom % 32'h800);
                check(alg, ALG_NORMAL);
                pulse(0, k);
                pulse(1, k);
                at(SLOT + 11);
                check(an_smoke, K_SMOKE[k] >> 2);
                check(alg, ALG_NORMAL);
                check(an_temp, (v == 0) ? temp : 16'h0000);
                pulse(2, k);
                at(2 * SLOT + 20);
                check(alg, exp_alg(k, v[1:0]));
                panel.rd(`OFFS_STATUS, d, r);
                check(d[4:0], exp_alg(k, v[1:0]));
            end
        end
        restart(VAR_FULL);
        for (int s = 0; s < 3; s++) pulse(s, 0);
        at(20 * SLOT + 20);
        check(alg, ALG_NORMAL);
        at(22 * SLOT + 20);
        check(alg, ALG_CLEAN);
        pulse(23, 0);
        at(23 * SLOT + 20);
        check(alg, ALG_NORMAL);
        restart(VAR_FULL);
        smoke <= 16'h0018;
        stored <= 16'h0010;
        @(posedge clk_sys_in);
        panel.wr(`OFFS_CTRL, 32'h1, r);
        check(r, 2'h0);
        at(16);
        check(comp_factor, 16'h0010);
        check(an_smoke, 16'h000c);
        panel.rd(`OFFS_FACTOR, d, r);
        check(d, 32'h10);
        smoke <= 16'h0030;
        at(28);
        check(comp_factor, `FACTOR_MAX);
        check(service, 1'b1);
        smoke <= '0;
        cnt(2, 28, c);
        check(c, 1);
        check(comp_factor < `FACTOR_MAX, 32'h1);
        loop_address <= 8'h00;
        repeat (2) @(posedge clk_sys_in);
        cnt(0, 32, c);
        check(c, 16);
        loop_address <= 8'($urandom % 255 + 1);
        repeat (2) @(posedge clk_sys_in);
        cnt(0, 32, c);
        check(c, 0);
        polling_en <= 1'b1;
        cnt(1, 28, c);
        check(c > 0, 32'h1);
        test_mode <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        cnt(1, 28, c);
        check(c, 0);
        self_fail <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        check(fault, 1'b1);
        panel.rd(`OFFS_STATUS, d, r);
        check(d[11], 1'b1);
        self_fail <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        check(fault, 1'b0);
        panel.rd(4'h2, d, r);
        check({r, d}, {2'h2, 32'h0});
        summarize();
    end
endmodule : tb
`default_nettype wire
